//--- commit_if.sv
// Handover of a completed subaddress write to the crossing logic
`timescale 1ns/1ps
`include "i2c_ctl_defs.svh"
interface commit_if;
  logic go;
  logic [7:0] sub;
  logic [4:0] len;
  logic [`STAGE_BYTES*8-1:0] data;
  logic busy;

  modport src (
    output go,
    output sub,
    output len,
    output data,
    input busy
  );

  modport dst (
    input go,
    input sub,
    input len,
    input data,
    output busy
  );
endinterface

//--- commit_xfer.sv
// Toggle handshake carrying completed writes into the processor domain
`timescale 1ns/1ps
`include "i2c_ctl_defs.svh"
module commit_xfer (
  // Control side
  commit_if.dst cif,
  input wire logic clk,
  input wire logic sys_rst,
  // Processor side
  input wire logic proc_clk,
  input wire logic proc_rst,
  output logic wr_valid,
  output logic [7:0] wr_sub,
  output logic [4:0] wr_len,
  output logic [`STAGE_BYTES*8-1:0] wr_data
);
  logic req_tgl_q;
  logic ack_meta_q;
  logic ack_sync_q;
  logic [7:0] hold_sub_q;
  logic [4:0] hold_len_q;
  logic [`STAGE_BYTES*8-1:0] hold_data_q;
  logic req_meta_q;
  logic req_sync_q;
  logic req_seen_q;

  // Held words stay still until the far side has echoed the toggle
  assign cif.busy = req_tgl_q ^ ack_sync_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_tgl_q <= 1'b0;
      hold_sub_q <= 8'h00;
      hold_len_q <= 5'h00;
      hold_data_q <= '0;
    end else if (cif.go && !cif.busy) begin
      req_tgl_q <= ~req_tgl_q;
      hold_sub_q <= cif.sub;
      hold_len_q <= cif.len;
      hold_data_q <= cif.data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= req_seen_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  always_ff @(posedge proc_clk) begin
    if (proc_rst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= req_tgl_q;
      req_sync_q <= req_meta_q;
    end
  end

  always_ff @(posedge proc_clk) begin
    if (proc_rst) begin
      req_seen_q <= 1'b0;
      wr_valid <= 1'b0;
      wr_sub <= 8'h00;
      wr_len <= 5'h00;
      wr_data <= '0;
    end else if (req_sync_q != req_seen_q) begin
      req_seen_q <= req_sync_q;
      wr_valid <= 1'b1;
      wr_sub <= hold_sub_q;
      wr_len <= hold_len_q;
      wr_data <= hold_data_q;
    end else begin
      wr_valid <= 1'b0;
    end
  end
endmodule

//--- i2c_control_slave.sv
// Two-wire control slave: framing, address match, subaddress access
`timescale 1ns/1ps
`include "i2c_ctl_defs.svh"
module i2c_control_slave (
  // Control clock, free of the audio master clock
  input wire logic clk,
  input wire logic sys_rst,
  // Audio processor clock
  input wire logic proc_clk,
  input wire logic proc_rst,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Register read port, same clock as clk
  output logic [7:0] rd_sub,
  output logic [4:0] rd_idx,
  input wire logic [7:0] rd_data,
  // Completed subaddress writes, processor clock
  output logic wr_valid,
  output logic [7:0] wr_sub,
  output logic [4:0] wr_len,
  output logic [`STAGE_BYTES*8-1:0] wr_data,
  // Status
  output logic bus_busy,
  output logic selected
);
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  logic pin_filt_q [2];
  logic [1:0] spike_cnt_q [2];
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_f;
  logic sda_f;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;

  i2c_ctl_pkg::link_state_e state_q;
  i2c_ctl_pkg::byte_kind_e kind_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic sda_oe_n_q;
  logic busy_q;
  logic sel_q;

  logic [7:0] sub_q;
  logic [4:0] cnt_q;
  logic [7:0] stage_q [`STAGE_BYTES];
  logic commit_q;
  logic [7:0] commit_sub_q;
  logic [4:0] commit_len_q;
  logic [7:0] addr_sel_q;

  logic byte_done;
  logic sub_v;
  logic data_v;
  logic rd_adv;
  logic [4:0] len_c;
  logic last_c;
  logic [6:0] my_addr;
  logic [7:0] rd_byte_c;

  commit_if cif ();

  // Length that a subaddress must receive before it is kept
  function automatic logic [4:0] sub_len(input logic [7:0] s);
    if (s <= `SUB_SHORT_MAX) begin
      return `LEN_SHORT;
    end else if ((s >= `SUB_FILT0_LO && s <= `SUB_FILT0_HI) ||
                 (s >= `SUB_FILT1_LO && s <= `SUB_FILT1_HI)) begin
      return `LEN_FILTER;
    end else begin
      return `LEN_WORD;
    end
  endfunction

  // Pins come from outside: two flops, then a spike filter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_q <= 2'h3;
      pin_sync_q <= 2'h3;
    end else begin
      pin_meta_q <= {scl_i, sda_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  // A level must differ for more than the spike time before it counts
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pin_filt_q[g] <= 1'b1;
          spike_cnt_q[g] <= 2'h0;
        end else if (pin_sync_q[g] == pin_filt_q[g]) begin
          spike_cnt_q[g] <= 2'h0;
        end else if (spike_cnt_q[g] == 2'(`SPIKE_CYC)) begin
          pin_filt_q[g] <= pin_sync_q[g];
          spike_cnt_q[g] <= 2'h0;
        end else begin
          spike_cnt_q[g] <= spike_cnt_q[g] + 2'h1;
        end
      end
    end
  endgenerate

  assign scl_f = pin_filt_q[1];
  assign sda_f = pin_filt_q[0];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  assign start_c = scl_f && scl_prev_q && sda_prev_q && !sda_f;
  assign stop_c = scl_f && scl_prev_q && !sda_prev_q && sda_f;
  assign scl_rise = scl_f && !scl_prev_q;
  assign scl_fall = !scl_f && scl_prev_q;

  assign my_addr = (addr_sel_q == {1'b0, `ADDR_ALT}) ?
                   `ADDR_ALT : `ADDR_DEFAULT;

  assign byte_done = !start_c && !stop_c && state_q == i2c_ctl_pkg::ST_RECV
                     && scl_fall && bit_cnt_q == `BYTE_BITS;
  assign sub_v = byte_done && kind_q == i2c_ctl_pkg::K_SUB;
  assign data_v = byte_done && kind_q == i2c_ctl_pkg::K_DATA;
  assign rd_adv = !start_c && !stop_c && state_q == i2c_ctl_pkg::ST_SACK
                  && scl_rise && !sda_f;
  assign len_c = sub_len(sub_q);
  assign last_c = cnt_q == len_c - 5'h01;

  // Unused bits of the select register read as zero
  assign rd_byte_c = (sub_q != `SUB_ADDR_SEL) ? rd_data :
                     (cnt_q == `SEL_BYTE) ? addr_sel_q : 8'h00;

  // Bit and byte engine; SCL is only ever sampled, never held low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= i2c_ctl_pkg::ST_IDLE;
      kind_q <= i2c_ctl_pkg::K_ADDR;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (start_c) begin
      state_q <= i2c_ctl_pkg::ST_RECV;
      kind_q <= i2c_ctl_pkg::K_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_c) begin
      state_q <= i2c_ctl_pkg::ST_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        i2c_ctl_pkg::ST_RECV: begin
          if (scl_rise && bit_cnt_q != `BYTE_BITS) begin
            shift_q <= {shift_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (byte_done) begin
            if (kind_q == i2c_ctl_pkg::K_ADDR &&
                shift_q[7:1] != my_addr) begin
              state_q <= i2c_ctl_pkg::ST_IDLE;
            end else begin
              state_q <= i2c_ctl_pkg::ST_RACK;
              sda_oe_n_q <= 1'b0;
              if (kind_q == i2c_ctl_pkg::K_ADDR) begin
                rw_q <= shift_q[0];
              end
            end
          end
        end
        i2c_ctl_pkg::ST_RACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (kind_q == i2c_ctl_pkg::K_ADDR && rw_q) begin
              state_q <= i2c_ctl_pkg::ST_SEND;
              sda_oe_n_q <= rd_byte_c[7];
              tx_q <= {rd_byte_c[6:0], 1'b0};
              bit_cnt_q <= 4'h1;
            end else begin
              state_q <= i2c_ctl_pkg::ST_RECV;
              sda_oe_n_q <= 1'b1;
              kind_q <= (kind_q == i2c_ctl_pkg::K_ADDR) ?
                        i2c_ctl_pkg::K_SUB : i2c_ctl_pkg::K_DATA;
            end
          end
        end
        i2c_ctl_pkg::ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_q == `BYTE_BITS) begin
              state_q <= i2c_ctl_pkg::ST_SACK;
              sda_oe_n_q <= 1'b1;
            end else begin
              sda_oe_n_q <= tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        i2c_ctl_pkg::ST_SACK: begin
          // A not-acknowledge ends the read; the stop follows
          if (scl_rise && sda_f) begin
            state_q <= i2c_ctl_pkg::ST_IDLE;
          end else if (scl_fall) begin
            state_q <= i2c_ctl_pkg::ST_SEND;
            sda_oe_n_q <= rd_byte_c[7];
            tx_q <= {rd_byte_c[6:0], 1'b0};
            bit_cnt_q <= 4'h1;
          end
        end
        default: begin
          state_q <= i2c_ctl_pkg::ST_IDLE;
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_n = sda_oe_n_q;

  // Subaddress pointer and byte count, shared by reads and writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sub_q <= 8'h00;
      cnt_q <= 5'h00;
    end else if (start_c || stop_c) begin
      cnt_q <= 5'h00;
    end else if (sub_v) begin
      sub_q <= shift_q;
      cnt_q <= 5'h00;
    end else if (data_v || rd_adv) begin
      if (last_c) begin
        sub_q <= sub_q + 8'h01;
        cnt_q <= 5'h00;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  assign rd_sub = sub_q;
  assign rd_idx = cnt_q;

  // Bytes wait here until their subaddress is complete
  always_ff @(posedge clk) begin
    if (data_v) begin
      stage_q[cnt_q] <= shift_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      commit_q <= 1'b0;
      commit_sub_q <= 8'h00;
      commit_len_q <= 5'h00;
    end else begin
      commit_q <= data_v && last_c;
      if (data_v && last_c) begin
        commit_sub_q <= sub_q;
        commit_len_q <= len_c;
      end
    end
  end

  // Address change takes effect from the next address byte on
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_sel_q <= `ADDR_SEL_RESET;
    end else if (commit_q && commit_sub_q == `SUB_ADDR_SEL) begin
      addr_sel_q <= stage_q[`SEL_BYTE];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      if (start_c) begin
        busy_q <= 1'b1;
      end else if (stop_c) begin
        busy_q <= 1'b0;
      end
      sel_q <= state_q != i2c_ctl_pkg::ST_IDLE &&
               !(state_q == i2c_ctl_pkg::ST_RECV &&
                 kind_q == i2c_ctl_pkg::K_ADDR);
    end
  end

  assign bus_busy = busy_q;
  assign selected = sel_q;

  // Byte i of a write lands in bits 8*i+7 down to 8*i
  generate
    for (g = 0; g < `STAGE_BYTES; g++) begin : g_pack
      assign cif.data[g*8 +: 8] = stage_q[g];
    end
  endgenerate

  // A byte lasts far longer than the handshake, so busy never blocks
  assign cif.go = commit_q;
  assign cif.sub = commit_sub_q;
  assign cif.len = commit_len_q;

  commit_xfer u_xfer (
    .cif(cif.dst),
    .clk(clk),
    .sys_rst(sys_rst),
    .proc_clk(proc_clk),
    .proc_rst(proc_rst),
    .wr_valid(wr_valid),
    .wr_sub(wr_sub),
    .wr_len(wr_len),
    .wr_data(wr_data)
  );
endmodule

//--- i2c_control_slave_monitor.sv
// Concurrent checks on the ports of the two-wire control slave
`timescale 1ns/1ps
`include "i2c_ctl_defs.svh"
module i2c_control_slave_monitor (
  // Clocks and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic proc_clk,
  input wire logic proc_rst,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe_n,
  // Pointer, commits and status
  input wire logic [7:0] rd_sub,
  input wire logic [4:0] rd_idx,
  input wire logic wr_valid,
  input wire logic [7:0] wr_sub,
  input wire logic [4:0] wr_len,
  input wire logic bus_busy,
  input wire logic selected
);
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  property p_start_busy;
    @(posedge clk) disable iff (sys_rst) s_start |-> ##[1:10] bus_busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy late after start");
  property p_stop_idle;
    @(posedge clk) disable iff (sys_rst) s_stop |-> ##[1:10] !bus_busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("busy stays after stop");
  // Filter latency is hidden inside the low phase of the bus clock
  property p_ack_steady;
    @(posedge clk) disable iff (sys_rst)
      scl_i && $past(scl_i) |-> $stable(sda_oe_n);
  endproperty
  a_ack_steady: assert property (p_ack_steady)
    else $error("data driver moved while clock high");
  property p_drive_sel;
    @(posedge clk) disable iff (sys_rst)
      $fell(sda_oe_n) |-> ##[0:3] selected;
  endproperty
  a_drive_sel: assert property (p_drive_sel)
    else $error("data line driven while not selected");
  property p_sel_busy;
    @(posedge clk) disable iff (sys_rst) $rose(selected) |-> bus_busy;
  endproperty
  a_sel_busy: assert property (p_sel_busy)
    else $error("selected outside a transfer");
  property p_stop_release;
    @(posedge clk) disable iff (sys_rst) $fell(bus_busy) |-> sda_oe_n;
  endproperty
  a_stop_release: assert property (p_stop_release)
    else $error("data line held after stop");
  property p_idx_range;
    @(posedge clk) disable iff (sys_rst)
      rd_idx < ((rd_sub <= `SUB_SHORT_MAX) ? `LEN_SHORT :
        (rd_sub inside {[`SUB_FILT0_LO:`SUB_FILT0_HI],
        [`SUB_FILT1_LO:`SUB_FILT1_HI]}) ? `LEN_FILTER : `LEN_WORD);
  endproperty
  a_idx_range: assert property (p_idx_range)
    else $error("byte index beyond subaddress length");
  property p_wr_pulse;
    @(posedge proc_clk) disable iff (proc_rst) wr_valid |=> !wr_valid;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("commit pulse too long");
  property p_wr_len;
    @(posedge proc_clk) disable iff (proc_rst)
      wr_valid |-> wr_len == ((wr_sub <= `SUB_SHORT_MAX) ? `LEN_SHORT :
        (wr_sub inside {[`SUB_FILT0_LO:`SUB_FILT0_HI],
        [`SUB_FILT1_LO:`SUB_FILT1_HI]}) ? `LEN_FILTER : `LEN_WORD);
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("commit length wrong for subaddress");
endmodule
bind i2c_control_slave i2c_control_slave_monitor i_mon (.clk, .sys_rst,
  .proc_clk, .proc_rst, .scl_i, .sda_i, .sda_oe_n, .rd_sub, .rd_idx,
  .wr_valid, .wr_sub, .wr_len, .bus_busy, .selected);

//--- i2c_ctl_defs.svh
// Constants for the two-wire control slave
//
// What this block does
// - The block is a slave only at 100 kHz and 400 kHz, never stretches SCL, adds no wait states and never arbitrates.
// - Each byte is eight bits sent most significant bit first, and its receiver answers with an acknowledge in the next clock period.
// - SDA falling while SCL is high is a start, SDA rising while SCL is high is a stop, and data bits change only while SCL is low.
// - The block acknowledges a byte addressed to it by holding SDA low for the whole acknowledge clock period.
// - The block answers to the 7-bit slave address 0x36 sent with the direction bit as the first byte after a start.
// - Writing 0x38 to the bus-address select register at subaddress 0xF9 moves the block from address 0x36 to address 0x38.
// - Subaddresses 0x00 to 0x1F take single- and multiple-byte access, and 0x20 to 0xFF take only whole groups of four bytes, or 20 at 0x29-0x3F and 0x58-0x5F.
// - A read returns successive bytes from the given subaddress while the master acknowledges, with unimplemented bits reading zero.
// - A write is counted against the length its subaddress needs (five 32-bit words for a filter), and data cut short by a stop or start is dropped.
// - A sequential write fills consecutive subaddresses from the first one, keeping each complete subaddress and dropping only an incomplete last one.
// - A write is start, address with direction 0, subaddress, data, stop, and the block acknowledges address, subaddress and every data byte.
// - A read writes the subaddress, then a repeated start with direction 1, after which the block acknowledges and sends data from that subaddress.
// - Any number of bytes may pass between start and stop, and the master's stop releases the bus.
// - The control logic runs on its own clock and keeps working without the audio master clock.
`ifndef I2C_CTL_DEFS_SVH
`define I2C_CTL_DEFS_SVH

`define ADDR_DEFAULT 7'h36
`define ADDR_ALT 7'h38
`define SUB_ADDR_SEL 8'hf9
`define ADDR_SEL_RESET 8'h00
`define SEL_BYTE 5'h03
`define SUB_SHORT_MAX 8'h1f
`define SUB_FILT0_LO 8'h29
`define SUB_FILT0_HI 8'h3f
`define SUB_FILT1_LO 8'h58
`define SUB_FILT1_HI 8'h5f
`define LEN_SHORT 5'h01
`define LEN_WORD 5'h04
`define LEN_FILTER 5'h14
`define STAGE_BYTES 20
`define BYTE_BITS 4'h8
`define CLK_MHZ 40
`define SPIKE_NS 50
`define SPIKE_CYC ((`SPIKE_NS * `CLK_MHZ) / 1000)

`endif

//--- i2c_ctl_pkg.sv
// Types shared by the two-wire control slave
package i2c_ctl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_RACK,
    ST_SEND,
    ST_SACK
  } link_state_e;

  typedef enum logic [1:0] {
    K_ADDR,
    K_SUB,
    K_DATA
  } byte_kind_e;

endpackage

//--- i2c_master_model.sv
// Bus master model driving the clock and data pins of the slave
`timescale 1ns/1ps
module i2c_master_model (
  // Bench clock and wire level
  input wire logic clk,
  input wire logic sda_i,
  // Driven pins, released level is the pull-up high
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Slow phases keep the slave's filter latency inside the clock low
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda = 1'b0;
    tick(10);
    scl = 1'b0;
    tick(5);
  endtask
  task automatic stop();
    sda = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda = 1'b1;
    tick(20);
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda = b;
    tick(5);
    scl = 1'b1;
    tick(5);
    r = sda_i;
    tick(5);
    scl = 1'b0;
    tick(5);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai,
      output logic [7:0] q, output logic ao);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ai, ao);
  endtask
endmodule

//--- tb_i2c_control_slave.sv
// Self-checking bench for the two-wire control slave
`timescale 1ns/1ps
`include "i2c_ctl_defs.svh"
module tb_i2c_control_slave;
  logic clk, sys_rst, proc_clk, proc_rst, scl_i, sda_m, sda_o, sda_oe_n;
  logic wr_valid, bus_busy, selected, k;
  logic [7:0] rd_sub, rd_data, wr_sub, q, sel, dat [0:23];
  logic [4:0] rd_idx, wr_len;
  logic [159:0] wr_data, qd [$];
  logic [7:0] qs [$];
  logic [4:0] ql [$];
  logic [7:0] cs [0:4] = '{8'h1f, 8'h20, 8'h29, 8'h58, 8'hfe};
  int cn [0:4] = '{6, 7, 20, 19, 9};
  int errors, n_checks;
  wire sda_i = sda_m & (sda_oe_n | sda_o);
  assign rd_data = rd_sub ^ {rd_idx, 3'h5};
  i2c_control_slave i_i2c_control_slave (.clk, .sys_rst, .proc_clk,
    .proc_rst, .scl_i, .sda_i, .sda_o, .sda_oe_n, .rd_sub, .rd_idx,
    .rd_data, .wr_valid, .wr_sub, .wr_len, .wr_data, .bus_busy,
    .selected);
  i2c_master_model i_i2c_master_model (.clk, .sda_i, .scl(scl_i),
    .sda(sda_m));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    proc_clk = 1'b0;
    #7;
    forever #15 proc_clk = ~proc_clk;
  end
  always @(posedge proc_clk) begin
    if (wr_valid === 1'b1) begin
      qs.push_back(wr_sub);
      ql.push_back(wr_len);
      qd.push_back(wr_data);
    end
  end
  function automatic logic [4:0] len_of(input logic [7:0] s);
    if (s <= `SUB_SHORT_MAX) return `LEN_SHORT;
    if (s inside {[`SUB_FILT0_LO:`SUB_FILT0_HI],
        [`SUB_FILT1_LO:`SUB_FILT1_HI]}) return `LEN_FILTER;
    return `LEN_WORD;
  endfunction
  function automatic logic [7:0] rd_exp(input logic [7:0] s,
      input logic [4:0] i);
    if (s == `SUB_ADDR_SEL) return (i == `SEL_BYTE) ? sel : 8'h00;
    return s ^ {i, 3'h5};
  endfunction
  task automatic chk(input logic [159:0] g, input logic [159:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_ack(input logic g, input logic e);
    chk(160'(g), 160'(e));
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    chk(160'(g), 160'(e));
  endtask
  task automatic chk_num(input int g, input int e);
    chk(160'(g), 160'(e));
  endtask
  task automatic put(input logic [7:0] b, input logic e);
    i_i2c_master_model.xfer(b, 1'b1, q, k);
    chk_ack(k, ~e);
  endtask
  task automatic wr_tr(input logic [6:0] a, input logic [7:0] s,
      input int n, input logic e);
    logic [7:0] p;
    int i, c;
    qs.delete();
    ql.delete();
    qd.delete();
    i_i2c_master_model.start();
    put({a, 1'b0}, e);
    put(s, e);
    for (int j = 0; j < n; j++) put(dat[j], e);
    i_i2c_master_model.stop();
    repeat (60) @(posedge clk);
    i = 0;
    c = 0;
    p = s;
    while (e && i + len_of(p) <= n) begin
      chk_byte(qs[c], p);
      chk_num(int'(ql[c]), int'(len_of(p)));
      for (int b = 0; b < len_of(p); b++) begin
        chk_byte(qd[c][8*b +: 8], dat[i+b]);
      end
      i += len_of(p);
      p++;
      c++;
    end
    chk_num(qs.size(), c);
  endtask
  task automatic rd_tr(input logic [6:0] a, input logic [7:0] s,
      input int n);
    logic [7:0] p;
    logic [4:0] x;
    p = s;
    x = 5'h00;
    i_i2c_master_model.start();
    put({a, 1'b0}, 1'b1);
    put(s, 1'b1);
    i_i2c_master_model.start();
    put({a, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_i2c_master_model.xfer(8'hff, 1'(i == n - 1), q, k);
      chk_byte(q, rd_exp(p, x));
      x++;
      if (x == len_of(p)) begin
        x = 5'h00;
        p++;
      end
    end
    i_i2c_master_model.stop();
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    sys_rst = 1'b1;
    proc_rst = 1'b1;
    sel = `ADDR_SEL_RESET;
    void'($urandom(32'h2c14));
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    proc_rst = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    for (int t = 0; t < 4; t++) begin
      foreach (dat[i]) dat[i] = 8'($urandom);
      wr_tr(`ADDR_DEFAULT, 8'($urandom_range(0, 31)),
        $urandom_range(1, 3), 1'b1);
    end
    $display("test random short writes done");
    foreach (cs[i]) wr_tr(`ADDR_DEFAULT, cs[i], cn[i], 1'b1);
    $display("test group boundaries done");
    rd_tr(`ADDR_DEFAULT, 8'h1e, 7);
    $display("test sequential read done");
    wr_tr(7'h37, 8'h05, 2, 1'b0);
    wr_tr(7'($urandom_range(0, 53)), 8'h05, 2, 1'b0);
    $display("test foreign address done");
    for (int i = 0; i < 3; i++) dat[i] = 8'h00;
    dat[3] = {1'b0, `ADDR_ALT};
    wr_tr(`ADDR_DEFAULT, `SUB_ADDR_SEL, 4, 1'b1);
    sel = dat[3];
    wr_tr(`ADDR_DEFAULT, 8'h05, 1, 1'b0);
    rd_tr(`ADDR_ALT, `SUB_ADDR_SEL, 4);
    $display("test alternate address done");
    end_sim();
  end
endmodule
